//--- hdl/pio_params.svh
// Purpose: constants for the isolated parallel i/o pair
// Assumes: word-wide host bus with byte addresses
// Notes: register index is address bits 2:1 above base
// Behaviour
// - output section drives 48 held lines, takes one interrupt input
// - input section samples 48 lines, takes one interrupt input
// - each section has its own switch-set base for many units
// - four words: control/status at base, three data words following
// - both control/status words share one layout
// - bit 6 is read/write interrupt enable gating the request
// - bit 7 is request, set by external interrupt input, cleared by a low-lane write to its own control/status word
// - interrupt raised while request is true and enable set
// - setting bit 8 acts like an external request
// - all other control/status bits do nothing and read zero
// - loaded output words drive lines until cleared or reset
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
`define PIO_WORD_W 16
`define PIO_LINES 48
`define PIO_ADDR_W 18
`define PIO_BASE_W 15
`define PIO_BASE_LSB 3
`define PIO_IDX_HI 2
`define PIO_IDX_LO 1
`define PIO_IDX_CSR 2'h0
`define PIO_IDX_A 2'h1
`define PIO_IDX_B 2'h2
`define PIO_IDX_C 2'h3
`define PIO_BIT_IE 6
`define PIO_BIT_REQ 7
`define PIO_BIT_MNT 8
`define PIO_LANE_LO 0
`define PIO_LANE_HI 1
`define PIO_SEC_OUT 0
`define PIO_SEC_IN 1
`endif

//--- hdl/pio_pkg.sv
// Purpose: shared types for the isolated parallel i/o pair
// Assumes: constants from the params header
// Notes: none
`include "pio_params.svh"
package pio_pkg;
   typedef logic [`PIO_WORD_W-1:0] pio_word_t;
   typedef logic [`PIO_LINES-1:0] pio_lines_t;
   typedef logic [`PIO_BASE_W-1:0] pio_base_t;
   typedef logic [`PIO_ADDR_W-1:0] pio_addr_t;
endpackage

//--- hdl/pio_top.sv
// Purpose: 48-line output section and 48-line input section on host bus
// Assumes: static base switches, one-cycle bus answer
// Notes: unmapped addresses get no ack; host times out
`timescale 1ns/1ps
`include "pio_params.svh"
module pio_top import pio_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // base address switches, one set per section
   input wire pio_base_t sw_out_base,
   input wire pio_base_t sw_in_base,
   // host register bus
   input wire pio_addr_t bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [1:0] bus_be,
   input wire pio_word_t bus_wdata,
   output pio_word_t bus_rdata,
   output logic bus_ack,
   // user side
   output pio_lines_t out_lines,
   input wire logic out_ext_req,
   input wire pio_lines_t in_lines,
   input wire logic in_ext_req,
   // interrupts to host
   output logic irq_out,
   output logic irq_in
);

   // address match against a section base and a word index
   function automatic logic hit(input pio_addr_t a, input pio_base_t b,
                                input logic [1:0] idx);
      hit = (a[`PIO_ADDR_W-1:`PIO_BASE_LSB] == b) &&
            (a[`PIO_IDX_HI:`PIO_IDX_LO] == idx);
   endfunction

   // switch and pin synchronisers
   pio_base_t sw_out_s1_r, sw_out_r, sw_in_s1_r, sw_in_r;
   pio_lines_t in_s1_r, in_r;
   logic [1:0] ext_s1_r, ext_s2_r, ext_s3_r;
   always_ff @(posedge clk) begin
      sw_out_s1_r <= sw_out_base;
      sw_out_r <= sw_out_s1_r;
      sw_in_s1_r <= sw_in_base;
      sw_in_r <= sw_in_s1_r;
      in_s1_r <= in_lines;
      in_r <= in_s1_r;
      ext_s1_r <= {in_ext_req, out_ext_req};
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
   end

   // decode, each section at its own base
   wire acc = bus_rd | bus_wr;
   wire [1:0] csr_hit = {hit(bus_addr, sw_in_r, `PIO_IDX_CSR),
                         hit(bus_addr, sw_out_r, `PIO_IDX_CSR)};
   wire out_hit_a = hit(bus_addr, sw_out_r, `PIO_IDX_A);
   wire out_hit_b = hit(bus_addr, sw_out_r, `PIO_IDX_B);
   wire out_hit_c = hit(bus_addr, sw_out_r, `PIO_IDX_C);
   wire in_hit_a = hit(bus_addr, sw_in_r, `PIO_IDX_A);
   wire in_hit_b = hit(bus_addr, sw_in_r, `PIO_IDX_B);
   wire in_hit_c = hit(bus_addr, sw_in_r, `PIO_IDX_C);
   wire any_hit = (|csr_hit) | out_hit_a | out_hit_b | out_hit_c |
                  in_hit_a | in_hit_b | in_hit_c;
   wire [1:0] csr_wr = csr_hit & {2{bus_wr}};
   wire [1:0] ext_rise = ext_s2_r & ~ext_s3_r;

   // control/status state, one copy per section with one layout
   logic [1:0] ie_r, req_r, mnt_r, irq_r;
   logic [1:0] ie_nxt, req_nxt, mnt_nxt;
   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_csr
         // enable in low lane, maintenance bit in high lane
         assign ie_nxt[k] = (csr_wr[k] && bus_be[`PIO_LANE_LO]) ?
                            bus_wdata[`PIO_BIT_IE] : ie_r[k];
         assign mnt_nxt[k] = (csr_wr[k] && bus_be[`PIO_LANE_HI]) ?
                             bus_wdata[`PIO_BIT_MNT] : mnt_r[k];
         // set wins over the clear done by a low-lane csr write
         assign req_nxt[k] = (ext_rise[k] | (mnt_nxt[k] & ~mnt_r[k])) ?
                             1'b1 :
                             ((csr_wr[k] && bus_be[`PIO_LANE_LO]) ?
                              1'b0 : req_r[k]);
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               ie_r[k] <= 1'b0;
               req_r[k] <= 1'b0;
               mnt_r[k] <= 1'b0;
               irq_r[k] <= 1'b0;
            end else begin
               ie_r[k] <= ie_nxt[k];
               req_r[k] <= req_nxt[k];
               mnt_r[k] <= mnt_nxt[k];
               irq_r[k] <= ie_r[k] & req_r[k];
            end
         end
      end
   endgenerate
   assign irq_out = irq_r[`PIO_SEC_OUT];
   assign irq_in = irq_r[`PIO_SEC_IN];

   // output words, byte-lane writable, 16 lines each in order
   pio_lines_t out_r;
   wire [2:0] out_wsel = {out_hit_c, out_hit_b, out_hit_a} & {3{bus_wr}};
   pio_lines_t out_nxt;
   generate
      for (k = 0; k < 6; k++) begin : g_lane
         assign out_nxt[k*8 +: 8] = (out_wsel[k/2] && bus_be[k%2]) ?
                                    bus_wdata[(k%2)*8 +: 8] :
                                    out_r[k*8 +: 8];
      end
   endgenerate
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_r <= '0;
      end else begin
         out_r <= out_nxt;
      end
   end
   assign out_lines = out_r;

   // csr image, unused bits zero
   function automatic pio_word_t csr_img(input logic ie, input logic rq,
                                         input logic mt);
      csr_img = '0;
      csr_img[`PIO_BIT_IE] = ie;
      csr_img[`PIO_BIT_REQ] = rq;
      csr_img[`PIO_BIT_MNT] = mt;
   endfunction

   // read mux and answer, registered
   wire pio_word_t rd_nxt =
      csr_hit[`PIO_SEC_OUT] ? csr_img(ie_r[0], req_r[0], mnt_r[0]) :
      csr_hit[`PIO_SEC_IN] ? csr_img(ie_r[1], req_r[1], mnt_r[1]) :
      out_hit_a ? out_r[0 +: `PIO_WORD_W] :
      out_hit_b ? out_r[`PIO_WORD_W +: `PIO_WORD_W] :
      out_hit_c ? out_r[2*`PIO_WORD_W +: `PIO_WORD_W] :
      in_hit_a ? in_r[0 +: `PIO_WORD_W] :
      in_hit_b ? in_r[`PIO_WORD_W +: `PIO_WORD_W] :
      in_hit_c ? in_r[2*`PIO_WORD_W +: `PIO_WORD_W] : '0;
   pio_word_t rdata_r;
   logic ack_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= '0;
         ack_r <= 1'b0;
      end else begin
         rdata_r <= bus_rd ? rd_nxt : '0;
         ack_r <= acc & any_hit;
      end
   end
   assign bus_rdata = rdata_r;
   assign bus_ack = ack_r;

   // checks
   sequence s_ext_rise(int i);
      !ext_s3_r[i] ##0 ext_s2_r[i];
   endsequence
   AST_EXT_SETS_REQ: assert property (@(posedge clk) disable iff (!rst_n)
      s_ext_rise(0) |=> req_r[0])
      else $error("ext request did not set request flag");
   AST_IN_EXT_SETS_REQ: assert property (@(posedge clk) disable iff (!rst_n)
      s_ext_rise(1) |=> req_r[1])
      else $error("input ext request did not set request flag");
   AST_IRQ_GATED: assert property (@(posedge clk) disable iff (!rst_n)
      (ie_r[0] && req_r[0]) |=> irq_out)
      else $error("irq missing with enable and request");
   AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (!rst_n)
      !ie_r[1] |=> !irq_in)
      else $error("irq raised while disabled");
   AST_MNT_SETS_REQ: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(mnt_r[0]) |-> req_r[0])
      else $error("maintenance bit did not set request");
   AST_CSR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      (bus_rd && |csr_hit) |=> (bus_rdata & 16'hFE3F) == 16'h0000)
      else $error("unused csr bit reads nonzero");
   AST_OUT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !(bus_wr && (out_hit_a || out_hit_b || out_hit_c)) |=>
      $stable(out_lines))
      else $error("output lines changed without a write");
   AST_OUT_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      (bus_wr && out_hit_b && bus_be == 2'h3) |=>
      out_lines[31:16] == $past(bus_wdata))
      else $error("second output word not loaded");
   AST_ACK_MAP: assert property (@(posedge clk) disable iff (!rst_n)
      ((bus_rd || bus_wr) && hit(bus_addr, sw_in_r, `PIO_IDX_C)) |=>
      bus_ack)
      else $error("mapped access not acked");
   AST_RESET_CLR: assert property (@(posedge clk)
      !rst_n |=> (out_lines == '0 && !irq_out && !irq_in))
      else $error("reset did not clear state");
endmodule

//--- tb/pio_user_model.sv
// Purpose: user equipment on the far side of the i/o pair
// Assumes: driven on rising clk edges only
// Notes: data is settled before its request pulse
`timescale 1ns/1ps
module pio_user_model import pio_pkg::*; (
   // clock
   input wire logic clk,
   // user lines
   input wire pio_lines_t out_lines,
   output pio_lines_t in_lines,
   output logic out_ext_req,
   output logic in_ext_req
);
   // idle levels at time zero
   initial begin
      in_lines = '0;
      out_ext_req = 1'b0;
      in_ext_req = 1'b0;
   end
   // present data, then flag it settled
   task automatic present(input pio_lines_t v);
      @(posedge clk);
      in_lines <= v;
      repeat (4) @(posedge clk);
      in_ext_req <= 1'b1;
      repeat (2) @(posedge clk);
      in_ext_req <= 1'b0;
   endtask
   // request pulse toward the output section
   task automatic poke_out();
      @(posedge clk);
      out_ext_req <= 1'b1;
      repeat (2) @(posedge clk);
      out_ext_req <= 1'b0;
   endtask
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench for the i/o pair
// Assumes: one-cycle ack after each mapped access
// Notes: distinct bases per section
`timescale 1ns/1ps
module testbench import pio_pkg::*;;
   localparam pio_base_t ob = 15'h0A00;
   localparam pio_base_t ib = 15'h0A01;
   localparam pio_addr_t oa = {ob, 3'h0};
   localparam pio_addr_t ia = {ib, 3'h0};
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [1:0] be = 2'h0;
   pio_addr_t addr = '0;
   pio_word_t wd = '0, rdata, q;
   logic ack, irq_o, irq_i, oreq, ireq, k;
   pio_lines_t out_l, in_l;
   int fail_count = 0, compares = 0;
   // clock at 200 MHz
   always #2.5 clk = ~clk;
   pio_top DUT (.clk(clk), .rst_n(rst_n), .sw_out_base(ob),
      .sw_in_base(ib), .bus_addr(addr), .bus_rd(rd), .bus_wr(wr),
      .bus_be(be), .bus_wdata(wd), .bus_rdata(rdata), .bus_ack(ack),
      .out_lines(out_l), .out_ext_req(oreq), .in_lines(in_l),
      .in_ext_req(ireq), .irq_out(irq_o), .irq_in(irq_i));
   pio_user_model U (.clk(clk), .out_lines(out_l), .in_lines(in_l),
      .out_ext_req(oreq), .in_ext_req(ireq));
   // compare and count
   task automatic chk(string n, logic [47:0] s, logic [47:0] e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h seen %h", n, e, s);
      end
   endtask
   // one bus access: one-cycle request pulse, answer taken at the ack edge
   task automatic bus(logic w, pio_addr_t a, pio_word_t d, logic [1:0] b,
                      logic x = 1'b1);
      int n;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wd <= d;
      be <= b;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      k = 1'b0;
      q = '0;
      for (n = 0; n < 4 && k !== 1'b1; n++) begin
         @(posedge clk);
         k = ack;
         q = rdata;
      end
      // a missing ack on a mapped access ends the run
      if (x && k !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED bus_ack exp 1 seen %b", k);
         summarize();
      end
   endtask
   // bounded wait for an interrupt level
   task automatic wait_irq(ref logic s);
      int n;
      for (n = 0; n < 20 && s !== 1'b1; n++) @(negedge clk);
      if (s !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED irq_wait exp 1 seen %b", s);
         summarize();
      end
   endtask
   task automatic t_reset();
      bus(0, oa, '0, 2'h0);
      chk("ack", k, 1);
      chk("ocsr", q, 0);
      chk("lines", out_l, 0);
      $display("test reset done");
   endtask
   task automatic t_out();
      bus(1, oa + 18'h2, 16'h1234, 2'h3);
      bus(1, oa + 18'h4, 16'h5678, 2'h3);
      bus(1, oa + 18'h6, 16'h9ABC, 2'h3);
      bus(1, oa + 18'h2, 16'hFFFF, 2'h1);
      chk("lines", out_l, 48'h9ABC_5678_12FF);
      bus(0, oa + 18'h4, '0, 2'h0);
      chk("word_b", q, 16'h5678);
      repeat (10) @(posedge clk);
      chk("held", out_l, 48'h9ABC_5678_12FF);
      $display("test output done");
   endtask
   task automatic t_in();
      bus(1, ia, 16'h0040, 2'h3);
      U.present(48'hA5A5_0F0F_C3C3);
      wait_irq(irq_i);
      chk("irq_in", irq_i, 1);
      bus(0, ia, '0, 2'h0);
      chk("icsr", q, 16'h00C0);
      bus(1, ia + 18'h2, 16'h0000, 2'h3);
      bus(0, ia + 18'h2, '0, 2'h0);
      chk("in_a", q, 16'hC3C3);
      bus(0, ia + 18'h4, '0, 2'h0);
      chk("in_b", q, 16'h0F0F);
      bus(0, ia + 18'h6, '0, 2'h0);
      chk("in_c", q, 16'hA5A5);
      bus(1, ia, 16'h0040, 2'h1);
      repeat (3) @(negedge clk);
      chk("irq_clr", irq_i, 0);
      $display("test input done");
   endtask
   task automatic t_mnt();
      U.poke_out();
      repeat (6) @(negedge clk);
      chk("irq_off", irq_o, 0);
      bus(0, oa, '0, 2'h0);
      chk("ocsr_req", q, 16'h0080);
      bus(1, oa, 16'h0000, 2'h3);
      bus(0, oa, '0, 2'h0);
      chk("ocsr_clr", q, 16'h0000);
      bus(1, oa, 16'hFFFF, 2'h3);
      bus(0, oa, '0, 2'h0);
      chk("ocsr", q, 16'h01C0);
      wait_irq(irq_o);
      chk("irq_out", irq_o, 1);
      bus(0, 18'h06000, '0, 2'h0, 1'b0);
      chk("unmapped", k, 0);
      $display("test maintenance done");
   endtask
   // verdict and end of run
   task automatic summarize();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_out();
      t_in();
      t_mnt();
      summarize();
   end
endmodule
